// *** rtl/tsp_pin_sync.sv ***
// Three-stage input synchroniser with agreement filter for pin inputs.
`timescale 1ns/1ps

module tsp_pin_sync #(
	parameter int WIDTH = 5
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic [WIDTH-1:0] pinAsync,
	output logic [WIDTH-1:0] pinLevel
);

	// ----------------------------------------------------------------
	// Stages
	// ----------------------------------------------------------------
	logic [WIDTH-1:0] stage1_r; // Metastable stage, read only by stage2
	logic [WIDTH-1:0] stage2_r; // First settled stage
	logic [WIDTH-1:0] stage3_r; // Second settled stage
	logic [WIDTH-1:0] level_r; // Accepted level

	initial begin
		if (WIDTH < 1) begin
			$error("tsp_pin_sync: WIDTH must be at least 1");
		end
	end

	// Shift chain; a change counts only when stage2 and stage3 agree
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			stage1_r <= '0;
			stage2_r <= '0;
			stage3_r <= '0;
			level_r <= '0;
		end else if (clkEn) begin
			stage1_r <= pinAsync;
			stage2_r <= stage1_r;
			stage3_r <= stage2_r;
			level_r <= (stage2_r & stage3_r) | (level_r & (stage2_r | stage3_r));
		end
	end

	assign pinLevel = level_r;

endmodule

// *** rtl/tsp_pkg.sv ***
// Package of constants shared by the synchronous serial port pin block.
package tsp_pkg;

	// ----------------------------------------------------------------
	// System clock and bit clock limits
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 25_000_000; // Rate of clk_sys
	localparam int unsigned BCLK_MIN_HZ = 512_000; // Slowest legal bit clock
	localparam int unsigned BCLK_MAX_HZ = 8_192_000; // Fastest legal bit clock
	// Half-period counts; the fastest clock rounds up so it never exceeds the limit
	localparam int unsigned DIV_MIN = (CLK_HZ + 2 * BCLK_MAX_HZ - 1) / (2 * BCLK_MAX_HZ);
	// The slowest clock rounds down so it never drops below the limit
	localparam int unsigned DIV_MAX = CLK_HZ / (2 * BCLK_MIN_HZ);
	localparam int DIV_W = 5; // Width of the half-period field

	// ----------------------------------------------------------------
	// Register bus layout
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8; // Byte address width
	localparam int DATA_W = 32; // Bus data width
	localparam int REG_LSB = 0; // Register select field position
	localparam int REG_W = 4; // Register select field width
	localparam int PORT_LSB = 4; // Port select field position
	localparam logic [REG_W-1:0] REG_CTRL = 4'h0; // Pin direction, edges, enable
	localparam logic [REG_W-1:0] REG_DIV = 4'h4; // Bit clock half-period
	localparam logic [REG_W-1:0] REG_TXDATA = 4'h8; // Transmit holding word
	localparam logic [REG_W-1:0] REG_STATUS = 4'hC; // Receive word and flags

	// ----------------------------------------------------------------
	// Control register fields (reset value: every pin an input)
	// ----------------------------------------------------------------
	localparam int CTRL_W = 7;
	localparam int CB_TXCLK_OUT = 0; // Drive the transmit bit clock
	localparam int CB_TXFS_OUT = 1; // Drive the transmit frame sync
	localparam int CB_RXCLK_OUT = 2; // Drive the receive bit clock
	localparam int CB_RXFS_OUT = 3; // Drive the receive frame sync
	localparam int CB_TX_RISE = 4; // Transmit launches on rising edge
	localparam int CB_RX_RISE = 5; // Receive samples on rising edge
	localparam int CB_ENABLE = 6; // Port enable
	localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;
	localparam logic [DIV_W-1:0] DIV_RESET = DIV_W'(DIV_MAX);

	// ----------------------------------------------------------------
	// Status register fields
	// ----------------------------------------------------------------
	localparam int SB_RX_VALID = 8; // Received word waiting
	localparam int SB_TX_FULL = 9; // Transmit holding word not yet taken
	localparam int SB_RX_OVERRUN = 10; // Received word lost
	localparam int SB_TX_UNDERRUN = 11; // Frame began with nothing to send

	// ----------------------------------------------------------------
	// Pin indices inside the synchroniser group
	// ----------------------------------------------------------------
	localparam int PIN_N = 5;
	localparam int PI_TXCLK = 0;
	localparam int PI_TXFS = 1;
	localparam int PI_RXCLK = 2;
	localparam int PI_RXFS = 3;
	localparam int PI_RXDATA = 4;

endpackage

// *** rtl/tsp_serial_port.sv ***
// Two synchronous serial ports with selectable pin directions and edges.
`timescale 1ns/1ps


module tsp_serial_port
	import tsp_pkg::*;
#(
	parameter int NUM_PORTS = 2,
	parameter int WORD_W = 8
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic [tsp_pkg::ADDR_W-1:0] regAddr,
	input wire logic [tsp_pkg::DATA_W-1:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	output logic [tsp_pkg::DATA_W-1:0] regRdData,
	input wire logic port0_tx_frame_sync_in,
	output logic port0_tx_frame_sync_out,
	output logic port0_tx_frame_sync_oe,
	output logic port0_tx_serial_data_out,
	output logic port0_tx_serial_data_oe,
	input wire logic port0_tx_bit_clock_in,
	output logic port0_tx_bit_clock_out,
	output logic port0_tx_bit_clock_oe,
	input wire logic port0_rx_frame_sync_in,
	output logic port0_rx_frame_sync_out,
	output logic port0_rx_frame_sync_oe,
	input wire logic port0_rx_serial_data,
	input wire logic port0_rx_bit_clock_in,
	output logic port0_rx_bit_clock_out,
	output logic port0_rx_bit_clock_oe,
	input wire logic port1_tx_frame_sync_in,
	output logic port1_tx_frame_sync_out,
	output logic port1_tx_frame_sync_oe,
	output logic port1_tx_serial_data_out,
	output logic port1_tx_serial_data_oe,
	input wire logic port1_tx_bit_clock_in,
	output logic port1_tx_bit_clock_out,
	output logic port1_tx_bit_clock_oe,
	input wire logic port1_rx_frame_sync_in,
	output logic port1_rx_frame_sync_out,
	output logic port1_rx_frame_sync_oe,
	input wire logic port1_rx_serial_data,
	input wire logic port1_rx_bit_clock_in,
	output logic port1_rx_bit_clock_out,
	output logic port1_rx_bit_clock_oe
);
	import tsp_pkg::*;

	localparam int CNT_W = $clog2(WORD_W + 1); // Bit counter width
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(WORD_W); // Word complete
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WORD_W - 1); // Last bit index
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	// Elaboration checks: the pin list serves exactly two ports, status holds words of up to 8 bits
	initial begin
		if (NUM_PORTS != 2) begin
			$error("tsp_serial_port: pin list serves exactly two ports");
		end
		if (WORD_W < 2 || WORD_W > SB_RX_VALID) begin
			$error("tsp_serial_port: WORD_W must lie in 2..8");
		end
	end

	// ----------------------------------------------------------------
	// Pin packing
	// ----------------------------------------------------------------
	logic [PIN_N-1:0] pinRaw [NUM_PORTS]; // Raw pin inputs per port
	logic [PIN_N-1:0] pinSync [NUM_PORTS]; // Synchronised pin levels
	logic txFsOut_r [NUM_PORTS]; // Transmit frame sync drive level
	logic txDataOe_r [NUM_PORTS]; // Open-drain pull-down enable
	logic txClkInt_r [NUM_PORTS]; // Generated transmit bit clock
	logic rxFsOut_r [NUM_PORTS]; // Receive frame sync drive level
	logic rxClkInt_r [NUM_PORTS]; // Generated receive bit clock
	logic [CTRL_W-1:0] ctrl_r [NUM_PORTS]; // Control register
	logic [DIV_W-1:0] div_r [NUM_PORTS]; // Half-period register
	logic [WORD_W-1:0] txHold_r [NUM_PORTS]; // Transmit holding word
	logic [WORD_W-1:0] rxHold_r [NUM_PORTS]; // Last received word
	logic txFull_r [NUM_PORTS]; // Holding word waiting
	logic rxValid_r [NUM_PORTS]; // Received word waiting
	logic rxOverrun_r [NUM_PORTS]; // Word overwritten unread
	logic txUnderrun_r [NUM_PORTS]; // Idle frame sent
	logic dataLow_r; // Open-drain output level, always low

	assign pinRaw[0] = {port0_rx_serial_data, port0_rx_frame_sync_in, port0_rx_bit_clock_in,
		port0_tx_frame_sync_in, port0_tx_bit_clock_in};
	assign pinRaw[1] = {port1_rx_serial_data, port1_rx_frame_sync_in, port1_rx_bit_clock_in,
		port1_tx_frame_sync_in, port1_tx_bit_clock_in};

	// Pins leave straight from flip-flops; clock and sync enables come from the control register, data enable from txDataOe_r
	assign port0_tx_frame_sync_out = txFsOut_r[0];
	assign port0_tx_frame_sync_oe = ctrl_r[0][CB_TXFS_OUT];
	assign port0_tx_serial_data_out = dataLow_r;
	assign port0_tx_serial_data_oe = txDataOe_r[0];
	assign port0_tx_bit_clock_out = txClkInt_r[0];
	assign port0_tx_bit_clock_oe = ctrl_r[0][CB_TXCLK_OUT];
	assign port0_rx_frame_sync_out = rxFsOut_r[0];
	assign port0_rx_frame_sync_oe = ctrl_r[0][CB_RXFS_OUT];
	assign port0_rx_bit_clock_out = rxClkInt_r[0];
	assign port0_rx_bit_clock_oe = ctrl_r[0][CB_RXCLK_OUT];
	assign port1_tx_frame_sync_out = txFsOut_r[1];
	assign port1_tx_frame_sync_oe = ctrl_r[1][CB_TXFS_OUT];
	assign port1_tx_serial_data_out = dataLow_r;
	assign port1_tx_serial_data_oe = txDataOe_r[1];
	assign port1_tx_bit_clock_out = txClkInt_r[1];
	assign port1_tx_bit_clock_oe = ctrl_r[1][CB_TXCLK_OUT];
	assign port1_rx_frame_sync_out = rxFsOut_r[1];
	assign port1_rx_frame_sync_oe = ctrl_r[1][CB_RXFS_OUT];
	assign port1_rx_bit_clock_out = rxClkInt_r[1];
	assign port1_rx_bit_clock_oe = ctrl_r[1][CB_RXCLK_OUT];

	// Open-drain data only ever pulls low, so its level flop is held at zero
	always_ff @(posedge clk_sys) begin
		dataLow_r <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Register bus decode
	// ----------------------------------------------------------------
	wire logic [REG_W-1:0] regSel = regAddr[REG_LSB +: REG_W];
	wire logic [ADDR_W-PORT_LSB-1:0] portSel = regAddr[ADDR_W-1:PORT_LSB];
	wire logic portOk = portSel < (ADDR_W - PORT_LSB)'(NUM_PORTS);
	wire logic pIdx = portSel[0];
	wire logic [DATA_W-1:0] statusWord = DATA_W'({txUnderrun_r[pIdx], rxOverrun_r[pIdx],
		txFull_r[pIdx], rxValid_r[pIdx], SB_RX_VALID'(rxHold_r[pIdx])});
	wire logic [DATA_W-1:0] rdNxt =
		!portOk ? '0 :
		(regSel == REG_CTRL) ? DATA_W'(ctrl_r[pIdx]) :
		(regSel == REG_DIV) ? DATA_W'(div_r[pIdx]) :
		(regSel == REG_TXDATA) ? DATA_W'(txHold_r[pIdx]) :
		(regSel == REG_STATUS) ? statusWord : '0;
	logic [DATA_W-1:0] rdData_r; // Read answer, valid only the cycle after the strobe

	// Read data: one cycle late, zero outside that cycle and for holes in the map
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rdData_r <= '0;
		end else if (clkEn) begin
			rdData_r <= regRdStb ? rdNxt : '0;
		end
	end
	assign regRdData = rdData_r;

	// ----------------------------------------------------------------
	// Input synchroniser for all pins of both ports
	// ----------------------------------------------------------------
	tsp_pin_sync #(
		.WIDTH(PIN_N * NUM_PORTS)
	) pinSyncInst (
		.clk_sys(clk_sys),
		.reset(reset),
		.clkEn(clkEn),
		.pinAsync({pinRaw[1], pinRaw[0]}),
		.pinLevel({pinSync[1], pinSync[0]})
	);

	// ----------------------------------------------------------------
	// Per-port logic
	// ----------------------------------------------------------------
	for (genvar p = 0; p < NUM_PORTS; p++) begin : gPort
		wire logic hit = portOk && (pIdx == 1'(p));
		wire logic wrCtrl = regWrStb && hit && (regSel == REG_CTRL);
		wire logic wrDiv = regWrStb && hit && (regSel == REG_DIV);
		wire logic wrTx = regWrStb && hit && (regSel == REG_TXDATA);
		wire logic rdStat = regRdStb && hit && (regSel == REG_STATUS);
		wire logic en = ctrl_r[p][CB_ENABLE];
		// Half-period written by software is held inside the legal bit clock range
		wire logic [DIV_W-1:0] divWr = regWrData[DIV_W-1:0];
		wire logic [DIV_W-1:0] divClamp =
			(divWr < DIV_W'(DIV_MIN)) ? DIV_W'(DIV_MIN) :
			(divWr > DIV_W'(DIV_MAX)) ? DIV_W'(DIV_MAX) : divWr;
		logic [DIV_W-1:0] txDivCnt_r; // Transmit divider count
		logic [DIV_W-1:0] rxDivCnt_r; // Receive divider count
		logic txClkPrev_r; // Previous transmit clock level
		logic rxClkPrev_r; // Previous receive clock level
		logic [CNT_W-1:0] txCnt_r; // Transmit bit index
		logic [CNT_W-1:0] rxCnt_r; // Received bit count, zero or CNT_FULL when idle
		logic [WORD_W-1:0] txShift_r; // Transmit shifter
		logic [WORD_W-1:0] rxShift_r; // Receive shifter

		// Control and divider registers; reset leaves every pin an input
		always_ff @(posedge clk_sys) begin
			if (reset) begin
				ctrl_r[p] <= CTRL_RESET;
				div_r[p] <= DIV_RESET;
			end else if (clkEn) begin
				if (wrCtrl) begin
					ctrl_r[p] <= regWrData[CTRL_W-1:0];
				end
				if (wrDiv) begin
					div_r[p] <= divClamp;
				end
			end
		end

		// Internal bit clocks: toggle once per half-period, held low while the port is disabled
		always_ff @(posedge clk_sys) begin
			if (reset) begin
				txDivCnt_r <= '0;
				rxDivCnt_r <= '0;
				txClkInt_r[p] <= 1'b0;
				rxClkInt_r[p] <= 1'b0;
			end else if (clkEn) begin
				txDivCnt_r <= (txDivCnt_r == '0) ? div_r[p] - DIV_W'(1) : txDivCnt_r - DIV_W'(1);
				rxDivCnt_r <= (rxDivCnt_r == '0) ? div_r[p] - DIV_W'(1) : rxDivCnt_r - DIV_W'(1);
				if (!en) begin
					txClkInt_r[p] <= 1'b0;
				end else if (txDivCnt_r == '0) begin
					txClkInt_r[p] <= ~txClkInt_r[p];
				end
				if (!en) begin
					rxClkInt_r[p] <= 1'b0;
				end else if (rxDivCnt_r == '0) begin
					rxClkInt_r[p] <= ~rxClkInt_r[p];
				end
			end
		end

		// Clock selection: own divider when driving the pin, else the synchronised pin
		wire logic txClk = ctrl_r[p][CB_TXCLK_OUT] ? txClkInt_r[p] : pinSync[p][PI_TXCLK];
		wire logic rxClk = ctrl_r[p][CB_RXCLK_OUT] ? rxClkInt_r[p] : pinSync[p][PI_RXCLK];
		wire logic txRise = txClk & ~txClkPrev_r;
		wire logic txFall = ~txClk & txClkPrev_r;
		wire logic rxRise = rxClk & ~rxClkPrev_r;
		wire logic rxFall = ~rxClk & rxClkPrev_r;
		wire logic txLaunch = en && (ctrl_r[p][CB_TX_RISE] ? txRise : txFall);
		wire logic rxSample = en && (ctrl_r[p][CB_RX_RISE] ? rxRise : rxFall);
		wire logic rxOther = en && (ctrl_r[p][CB_RX_RISE] ? rxFall : rxRise);
		// Frame start: own counter when driving sync, else the partner's marker
		wire logic txStart = ctrl_r[p][CB_TXFS_OUT] ? (txCnt_r == CNT_LAST)
			: pinSync[p][PI_TXFS];
		wire logic rxStart = ctrl_r[p][CB_RXFS_OUT] ? (rxCnt_r == '0 || rxCnt_r == CNT_FULL)
			: pinSync[p][PI_RXFS];
		wire logic [WORD_W-1:0] txLoad = txFull_r[p] ? txHold_r[p] : '1;
		wire logic [WORD_W-1:0] txShiftNxt = txStart ? txLoad : {txShift_r[WORD_W-2:0], 1'b1};
		wire logic [WORD_W-1:0] rxShiftNxt = {rxShift_r[WORD_W-2:0], pinSync[p][PI_RXDATA]};
		wire logic rxMore = rxCnt_r != '0 && rxCnt_r != CNT_FULL;
		wire logic [CNT_W-1:0] rxCntNxt = rxStart ? CNT_ONE : rxCnt_r + CNT_ONE;
		wire logic rxDone = rxSample && (rxStart || rxMore) && rxCntNxt == CNT_FULL;
		wire logic txTake = txLaunch && txStart && txFull_r[p];
		wire logic txIdle = txLaunch && txStart && !txFull_r[p];

		// Edge history of the chosen clocks
		always_ff @(posedge clk_sys) begin
			if (reset) begin
				txClkPrev_r <= 1'b0;
				rxClkPrev_r <= 1'b0;
			end else if (clkEn) begin
				txClkPrev_r <= txClk;
				rxClkPrev_r <= rxClk;
			end
		end

		// Transmit: sync and data change together on the launch edge
		always_ff @(posedge clk_sys) begin
			if (reset) begin
				txCnt_r <= CNT_LAST;
				txShift_r <= '1;
				txFsOut_r[p] <= 1'b0;
				txDataOe_r[p] <= 1'b0;
			end else if (clkEn) begin
				if (!en) begin
					txCnt_r <= CNT_LAST;
					txShift_r <= '1;
					txFsOut_r[p] <= 1'b0;
					txDataOe_r[p] <= 1'b0;
				end else if (txLaunch) begin
					txCnt_r <= txStart ? '0 : ((txCnt_r == CNT_LAST) ? CNT_LAST : txCnt_r + CNT_ONE);
					txShift_r <= txShiftNxt;
					txFsOut_r[p] <= txStart && ctrl_r[p][CB_TXFS_OUT];
					// Pull low for a zero, release for a one
					txDataOe_r[p] <= ~txShiftNxt[WORD_W-1];
				end
			end
		end

		// Receive: shift on the sample edge, drive own sync on the other edge
		always_ff @(posedge clk_sys) begin
			if (reset) begin
				rxCnt_r <= '0;
				rxShift_r <= '0;
				rxFsOut_r[p] <= 1'b0;
			end else if (clkEn) begin
				if (!en) begin
					rxCnt_r <= '0;
					rxFsOut_r[p] <= 1'b0;
				end else begin
					if (rxSample && (rxStart || rxMore)) begin
						rxCnt_r <= rxCntNxt;
						rxShift_r <= rxShiftNxt;
					end
					if (rxOther) begin
						rxFsOut_r[p] <= ctrl_r[p][CB_RXFS_OUT] &&
							(rxCnt_r == '0 || rxCnt_r == CNT_FULL);
					end
				end
			end
		end

		// Data words and sticky flags; a hardware set wins over a clearing read, except rxOverrun_r, which a read always clears
		always_ff @(posedge clk_sys) begin
			if (reset) begin
				txHold_r[p] <= '0;
				rxHold_r[p] <= '0;
				txFull_r[p] <= 1'b0;
				rxValid_r[p] <= 1'b0;
				rxOverrun_r[p] <= 1'b0;
				txUnderrun_r[p] <= 1'b0;
			end else if (clkEn) begin
				if (wrTx) begin
					txHold_r[p] <= regWrData[WORD_W-1:0];
				end
				// A write in the same cycle as a take refills the holding word
				txFull_r[p] <= wrTx || (txFull_r[p] && !txTake);
				if (rxDone) begin
					rxHold_r[p] <= rxShiftNxt;
				end
				rxValid_r[p] <= rxDone || (rxValid_r[p] && !rdStat);
				rxOverrun_r[p] <= (rxDone && rxValid_r[p] && !rdStat) ||
					(rxOverrun_r[p] && !rdStat);
				txUnderrun_r[p] <= txIdle || (txUnderrun_r[p] && !rdStat);
			end
		end
	end

endmodule

// *** tb/tb.sv ***
// Self-checking bench for the two-port synchronous serial pin block.
`timescale 1ns/1ps

module tb;
	import tsp_pkg::*;
	logic clk_sys, reset, clkEn, regWrStb, regRdStb;
	logic [7:0] regAddr;
	logic [31:0] regWrData;
	logic [31:0] regRdData;
	logic [3:0] oe0, oe1, out1; // Per port: tx clk, tx sync, rx clk, rx sync
	logic dOe0, dOe1;
	wire lkClk, lkFs, lkDat;
	wire p0Line = ~dOe0; // Pull-up supplies the high level
	wire p1Line = ~dOe1;
	int failures = 0, nTests = 0, cycles = 0, e, per;
	logic [7:0] w;
	logic [4:0] dIn [3] = '{5'h01, 5'h1F, 5'h04};
	logic [4:0] dOut [3] = '{5'h02, 5'h18, 5'h04};

	// ----------------------------------------------------------------
	// Clock, timeout and instances
	// ----------------------------------------------------------------
	always #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			report_and_stop();
		end
	end

	tsp_link_partner LINK (.bitClk(lkClk), .frameSync(lkFs), .serData(lkDat), .txLine(p0Line),
		.gotWord());

	// Port 1 pins resolve to the device level when driven, else the pull-up
	tsp_serial_port DUT (.clk_sys(clk_sys), .reset(reset), .clkEn(clkEn), .regAddr(regAddr),
		.regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
		.port0_tx_frame_sync_in(lkFs), .port0_tx_frame_sync_out(), .port0_tx_frame_sync_oe(oe0[1]),
		.port0_tx_serial_data_out(), .port0_tx_serial_data_oe(dOe0),
		.port0_tx_bit_clock_in(lkClk), .port0_tx_bit_clock_out(), .port0_tx_bit_clock_oe(oe0[0]),
		.port0_rx_frame_sync_in(lkFs), .port0_rx_frame_sync_out(), .port0_rx_frame_sync_oe(oe0[3]),
		.port0_rx_serial_data(lkDat), .port0_rx_bit_clock_in(lkClk), .port0_rx_bit_clock_out(),
		.port0_rx_bit_clock_oe(oe0[2]), .port1_tx_frame_sync_in(oe1[1] ? out1[1] : 1'b1),
		.port1_tx_frame_sync_out(out1[1]), .port1_tx_frame_sync_oe(oe1[1]),
		.port1_tx_serial_data_out(), .port1_tx_serial_data_oe(dOe1),
		.port1_tx_bit_clock_in(oe1[0] ? out1[0] : 1'b1), .port1_tx_bit_clock_out(out1[0]),
		.port1_tx_bit_clock_oe(oe1[0]), .port1_rx_frame_sync_in(oe1[3] ? out1[3] : 1'b1),
		.port1_rx_frame_sync_out(out1[3]), .port1_rx_frame_sync_oe(oe1[3]),
		.port1_rx_serial_data(p1Line), .port1_rx_bit_clock_in(oe1[2] ? out1[2] : 1'b1),
		.port1_rx_bit_clock_out(out1[2]), .port1_rx_bit_clock_oe(oe1[2]));

	// ----------------------------------------------------------------
	// Bus tasks and comparison
	// ----------------------------------------------------------------
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		nTests++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'b1;
		@(posedge clk_sys);
		regWrStb <= 1'b0;
		#1;
	endtask

	// Read data stand only in the cycle after the strobe
	task rd(input logic [7:0] a, input logic [31:0] exp);
		regAddr <= a;
		regRdStb <= 1'b1;
		@(posedge clk_sys);
		regRdStb <= 1'b0;
		#1;
		chk("read data", exp, regRdData);
	endtask

	// Collects one port 1 frame on falling edges of its generated clock
	task grab_tx(output logic [7:0] q, output int pd);
		int n, k, last;
		logic prev;
		k = 0;
		last = 0;
		q = 8'h00;
		pd = 0;
		for (n = 0; n < 2000 && k < 8; n++) begin
			prev = out1[0];
			@(posedge clk_sys);
			#1;
			if (prev && !out1[0]) begin
				if (k > 0 || out1[1]) begin
					q = {q[6:0], p1Line};
					k++;
				end
				pd = n - last;
				last = n;
			end
		end
	endtask

	task report_and_stop;
		$display("comparisons %0d mismatches %0d", nTests, failures);
		if (failures == 0 && nTests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		reset = 1'b1;
		clkEn = 1'b1;
		regAddr = 8'h00;
		regWrData = 32'h0;
		regWrStb = 1'b0;
		regRdStb = 1'b0;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		#1;
		chk("enables after reset", 32'h0, 32'({oe0, oe1, dOe0, dOe1}));
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h18);
		rd(8'h1C, 32'h0);
		rd(8'h20, 32'h0);
		// Port 0 timed by the far end, both edge choices in turn
		for (e = 0; e < 2; e++) begin
			wr(8'h08, 32'(8'hA5 ^ {8{e[0]}}));
			wr(8'h00, e ? 32'h70 : 32'h40);
			LINK.frame(8'h3C ^ {8{e[0]}}, e[0]);
			chk("port0 tx word", 32'(8'hA5 ^ {8{e[0]}}), 32'(LINK.gotWord));
			rd(8'h0C, 32'h100 | 32'(8'h3C ^ {8{e[0]}}));
		end
		chk("port0 enables", 32'h0, 32'({oe0}));
		// Frame with nothing held sends all ones and flags underrun
		LINK.frame(8'h00, 1'b1);
		chk("underrun word", 32'hFF, 32'(LINK.gotWord));
		rd(8'h0C, 32'h900);
		// Port 1: half period clamp, then every clock and sync pin driven by the device
		for (e = 0; e < 3; e++) begin
			wr(8'h14, 32'(dIn[e]));
			rd(8'h14, 32'(dOut[e]));
		end
		wr(8'h18, 32'h5A);
		wr(8'h10, 32'h7F);
		repeat (2) @(posedge clk_sys);
		#1;
		chk("port1 enables", 32'hF, 32'(oe1));
		grab_tx(w, per);
		chk("port1 tx word", 32'h5A, 32'(w));
		chk("tx clock period", 32'd8, 32'(per));
		wr(8'h10, 32'h0);
		repeat (2) @(posedge clk_sys);
		#1;
		chk("port1 released", 32'h0, 32'({oe1, dOe1}));
		// Loopback: first sample sees the idle line, then the word one bit late
		rd(8'h1C, 32'h1AD);
		report_and_stop();
	end
endmodule

// *** tb/tsp_link_partner.sv ***
// Behavioural far-end framer that supplies bit clock, frame sync and data.
`timescale 1ns/1ps

module tsp_link_partner (
	output logic bitClk,
	output logic frameSync,
	output logic serData,
	input wire logic txLine,
	output logic [7:0] gotWord
);
	// ----------------------------------------------------------------
	// Idle: clock stands high, sync low, pins always driven
	// ----------------------------------------------------------------
	initial begin
		bitClk = 1'b1;
		frameSync = 1'b0;
		serData = 1'b1;
		gotWord = 8'h00;
	end

	// One frame at 3.125 MHz; data and sync change mid high phase so either edge
	// can sample them, and the device's line is read 240 ns after its launch edge
	task automatic frame(input logic [7:0] w, input logic rise);
		int i;
		begin
			gotWord = 8'h00;
			frameSync = 1'b1;
			serData = w[7];
			#80;
			for (i = 0; i <= 8; i++) begin
				bitClk = 1'b0;
				#80;
				if (rise && i > 0) gotWord = {gotWord[6:0], txLine};
				if (i < 8) begin
					#80;
					bitClk = 1'b1;
					#80;
					if (!rise) gotWord = {gotWord[6:0], txLine};
					frameSync = 1'b0;
					// After the last bit the line shows the inverse, not a stale value
					serData = (i < 7) ? w[6 - i] : ~w[0];
					#80;
				end
			end
			#80;
			bitClk = 1'b1;
		end
	endtask
endmodule

// *** tb/tsp_serial_port_sva.sv ***
// Concurrent checks on the serial port pin directions, clocks and drain.
`timescale 1ns/1ps

module tsp_serial_port_sva
	import tsp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic [tsp_pkg::ADDR_W-1:0] regAddr,
	input wire logic [tsp_pkg::DATA_W-1:0] regWrData,
	input wire logic regWrStb,
	input wire logic port0_tx_frame_sync_oe,
	input wire logic port0_tx_serial_data_out,
	input wire logic port0_tx_serial_data_oe,
	input wire logic port1_tx_serial_data_out,
	input wire logic port1_tx_serial_data_oe,
	input wire logic port1_tx_bit_clock_out,
	input wire logic port1_tx_bit_clock_oe,
	input wire logic port1_rx_bit_clock_out,
	input wire logic port1_rx_frame_sync_oe
);
	// ----------------------------------------------------------------
	// Single clock domain, synchronous reset
	// ----------------------------------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);

	// Checked sync and clock pins are inputs, and both drains released, in the first cycle after reset
	rst_inputs_a: assert property ($fell(reset) |-> !(port0_tx_frame_sync_oe
		|| port1_tx_bit_clock_oe || port1_rx_frame_sync_oe)) else $error("pin driven after reset");
	drain_released_a: assert property ($fell(reset) |-> !port0_tx_serial_data_oe
		&& !port1_tx_serial_data_oe) else $error("data line pulled low after reset");
	// Open drain: the driven level is only ever low
	pull_only_a: assert property (!port0_tx_serial_data_out
		&& !port1_tx_serial_data_out) else $error("data line driven high");
	// Direction bits follow the control write within two cycles
	txfs_dir_a: assert property (regWrStb && clkEn && regAddr == 8'h00 |-> ##2
		port0_tx_frame_sync_oe == $past(regWrData[1], 2)) else $error("tx sync direction");
	rxfs_dir_a: assert property (regWrStb && clkEn && regAddr == 8'h10 |-> ##2
		port1_rx_frame_sync_oe == $past(regWrData[3], 2)) else $error("rx sync direction");
	// A half period of one cycle would exceed the fastest legal bit clock
	txclk_half_a: assert property ($changed(port1_tx_bit_clock_out) |=>
		$stable(port1_tx_bit_clock_out)) else $error("tx clock half period too short");
	rxclk_half_a: assert property ($changed(port1_rx_bit_clock_out) |=>
		$stable(port1_rx_bit_clock_out)) else $error("rx clock half period too short");
	// Driving starts only as the result of a software write
	drive_cause_a: assert property ($rose(port1_tx_bit_clock_oe) |->
		$past(regWrStb) || $past(regWrStb, 2)) else $error("clock driven without write");

	cover property ($rose(port1_tx_bit_clock_oe));
	cover property ($fell(port0_tx_serial_data_oe));
	cover property ($rose(port1_rx_frame_sync_oe));
endmodule

bind tsp_serial_port tsp_serial_port_sva CHK (.clk_sys(clk_sys), .reset(reset), .clkEn(clkEn),
	.regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
	.port0_tx_frame_sync_oe(port0_tx_frame_sync_oe),
	.port0_tx_serial_data_out(port0_tx_serial_data_out),
	.port0_tx_serial_data_oe(port0_tx_serial_data_oe),
	.port1_tx_serial_data_out(port1_tx_serial_data_out),
	.port1_tx_serial_data_oe(port1_tx_serial_data_oe),
	.port1_tx_bit_clock_out(port1_tx_bit_clock_out),
	.port1_tx_bit_clock_oe(port1_tx_bit_clock_oe),
	.port1_rx_bit_clock_out(port1_rx_bit_clock_out),
	.port1_rx_frame_sync_oe(port1_rx_frame_sync_oe));
